// *** rtl/usbrhb_cfg.svh ***
`ifndef USBRHB_CFG_SVH
`define USBRHB_CFG_SVH

// register byte address
`define USBRHB_ADDR_PORT_CFG_B 32'hFFF0504C
// power-on value of the register
`define USBRHB_RESET_PORT_CFG_B 32'h00000000
// field positions
`define USBRHB_REMOVABLE_LSB 0
`define USBRHB_REMOVABLE_MSB 15
`define USBRHB_SELECT_LSB 16
`define USBRHB_SELECT_MSB 31
`define USBRHB_FIELD_W 16
// implemented downstream ports
`define USBRHB_NUM_PORTS 2
// value returned for an unmapped read
`define USBRHB_UNMAPPED_DATA 32'h00000000

`endif

// *** rtl/usbrhb_pkg.sv ***
package usbrhb_pkg;

  typedef enum logic [1:0] {
    mode_always_on,
    mode_ganged,
    mode_per_port
  } usbrhb_mode_t;

  typedef logic [15:0] usbrhb_field_t;

endpackage

// *** rtl/usbrhb_power.sv ***
`include "usbrhb_cfg.svh"

module usbrhb_power
  import usbrhb_pkg::*;
#(
  parameter int NUM_PORTS = `USBRHB_NUM_PORTS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ports_always_on_setting,
  input wire logic per_port_switch_select,
  input wire logic [NUM_PORTS:1] port_power_select_mask,
  input wire logic set_global_power,
  input wire logic clear_global_power,
  input wire logic [NUM_PORTS:1] set_port_power,
  input wire logic [NUM_PORTS:1] clear_port_power,
  output logic [NUM_PORTS:1] port_power
);

  usbrhb_mode_t mode;
  logic [NUM_PORTS:1] next_port_power;

  always_comb begin
    if (ports_always_on_setting) begin
      mode = mode_always_on;
    end else if (per_port_switch_select) begin
      mode = mode_per_port; // R3
    end else begin
      mode = mode_ganged;
    end
  end

  ////////////////////////////////////////////////////////////////
  // clear beats set on the same port: a late off is the safe side
  always_comb begin
    next_port_power = port_power;
    for (int p = 1; p <= NUM_PORTS; p++) begin
      case (mode)
        mode_always_on: begin
          next_port_power[p] = 1'b1;
        end
        mode_per_port: begin
          if (port_power_select_mask[p]) begin
            if (clear_port_power[p]) begin
              next_port_power[p] = 1'b0; // R4
            end else if (set_port_power[p]) begin
              next_port_power[p] = 1'b1; // R4
            end
          end else begin
            if (clear_global_power) begin
              next_port_power[p] = 1'b0; // R4
            end else if (set_global_power) begin
              next_port_power[p] = 1'b1; // R4
            end
          end
        end
        default: begin
          // mask ignored outside per-port mode
          if (clear_global_power) begin
            next_port_power[p] = 1'b0; // R3
          end else if (set_global_power) begin
            next_port_power[p] = 1'b1; // R3
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_power <= '0;
    end else begin
      port_power <= next_port_power;
    end
  end

endmodule

// *** rtl/usbrhb_top.sv ***
`include "usbrhb_cfg.svh"

// Overview of operation
// R1 - register clears to zero on power-on reset only; bus reset leaves it alone
// R2 - software programs it once at start-up, not during normal operation
// R3 - mask only matters when ports switch and individual mode is selected
// R4 - mask one: per-port commands drive port; mask zero: global commands only
// R5 - bit 0 reserved, bit n is port n; unimplemented bits read zero
// R6 - removable flag one means removable device, zero means fixed device
// R7 - two ports implemented; only bits 1 and 2 of each field exist
// R8 - removable flags in bits 15:0, power select mask in bits 31:16
module usbrhb_top
  import usbrhb_pkg::*;
#(
  parameter int NUM_PORTS = `USBRHB_NUM_PORTS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic usb_bus_reset,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ports_always_on_setting,
  input wire logic per_port_switch_select,
  input wire logic set_global_power,
  input wire logic clear_global_power,
  input wire logic [NUM_PORTS:1] set_port_power,
  input wire logic [NUM_PORTS:1] clear_port_power,
  output logic [NUM_PORTS:1] port_power,
  output logic [NUM_PORTS:1] port_removable_flags,
  output logic [NUM_PORTS:1] port_power_select_mask
);

  // bits that exist: ports 1..NUM_PORTS, never bit 0
  function automatic usbrhb_field_t impl_mask();
    usbrhb_field_t m;
    m = '0;
    for (int p = 1; p <= NUM_PORTS; p++) begin
      m[p] = 1'b1; // R5 R7
    end
    return m;
  endfunction

  function automatic logic hit(input logic [31:0] a);
    return (a == `USBRHB_ADDR_PORT_CFG_B);
  endfunction

  usbrhb_field_t removable;
  usbrhb_field_t select_mask;
  usbrhb_field_t next_removable;
  usbrhb_field_t next_select_mask;
  logic [31:0] next_reg_rdata;

  ////////////////////////////////////////////////////////////////
  // register write; usb_bus_reset deliberately has no effect here
  always_comb begin
    next_removable = removable;
    next_select_mask = select_mask;
    if (reg_wr && hit(reg_addr)) begin
      next_removable = reg_wdata[`USBRHB_REMOVABLE_MSB:`USBRHB_REMOVABLE_LSB] & impl_mask(); // R5 R6 R8
      next_select_mask = reg_wdata[`USBRHB_SELECT_MSB:`USBRHB_SELECT_LSB] & impl_mask(); // R5 R8
    end
  end

  // only the power-on reset clears the fields
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      removable <= usbrhb_field_t'(`USBRHB_RESET_PORT_CFG_B >> `USBRHB_REMOVABLE_LSB); // R1
      select_mask <= usbrhb_field_t'(`USBRHB_RESET_PORT_CFG_B >> `USBRHB_SELECT_LSB); // R1
    end else begin
      removable <= next_removable;
      select_mask <= next_select_mask;
    end
  end

  ////////////////////////////////////////////////////////////////
  // read data valid the cycle after the strobe, zero otherwise
  always_comb begin
    next_reg_rdata = 32'h00000000;
    if (reg_rd) begin
      if (hit(reg_addr)) begin
        next_reg_rdata = {select_mask, removable}; // R8
      end else begin
        next_reg_rdata = `USBRHB_UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  assign port_removable_flags = removable[NUM_PORTS:1]; // R6
  assign port_power_select_mask = select_mask[NUM_PORTS:1];

  ////////////////////////////////////////////////////////////////
  usbrhb_power #(
    .NUM_PORTS(NUM_PORTS)
  ) u_power (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ports_always_on_setting(ports_always_on_setting),
    .per_port_switch_select(per_port_switch_select),
    .port_power_select_mask(select_mask[NUM_PORTS:1]),
    .set_global_power(set_global_power),
    .clear_global_power(clear_global_power),
    .set_port_power(set_port_power),
    .clear_port_power(clear_port_power),
    .port_power(port_power)
  );

endmodule

// *** testbench/usbrhb_assertions.sv ***
`include "usbrhb_cfg.svh"
module usbrhb_chk
  import usbrhb_pkg::*;
#(parameter int NUM_PORTS = 2) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic usb_bus_reset,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic ports_always_on_setting,
  input wire logic per_port_switch_select,
  input wire logic set_global_power,
  input wire logic clear_global_power,
  input wire logic [NUM_PORTS:1] clear_port_power,
  input wire logic [NUM_PORTS:1] port_power,
  input wire logic [NUM_PORTS:1] port_removable_flags,
  input wire logic [NUM_PORTS:1] port_power_select_mask
);
  logic hit;
  logic sw;
  assign hit = reg_addr == `USBRHB_ADDR_PORT_CFG_B;
  assign sw = !ports_always_on_setting;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence rd_req;
    reg_rd && hit;
  endsequence
  ////////////////////////////////////////////////////////////
  wr_fields_a: assert property (reg_wr && hit |=> port_removable_flags == $past(reg_wdata[2:1])
    && port_power_select_mask == $past(reg_wdata[18:17])) else $error("field update wrong");
  rd_word_a: assert property (rd_req |=> reg_rdata == {13'h0000, port_power_select_mask, 1'b0,
    13'h0000, port_removable_flags, 1'b0}) else $error("read word wrong");
  rd_idle_a: assert property (!(reg_rd && hit) |=> reg_rdata == 32'h00000000) else $error("stray read data");
  bus_rst_a: assert property (usb_bus_reset && !reg_wr |=> $stable(port_removable_flags)
    && $stable(port_power_select_mask)) else $error("bus reset touched register");
  always_on_a: assert property (!sw |=> &port_power) else $error("ports not forced on");
  global_set_a: assert property (sw && !per_port_switch_select && set_global_power && !clear_global_power
    |=> &port_power) else $error("global set missed");
  port_clr_a: assert property (sw && per_port_switch_select && port_power_select_mask[1]
    && clear_port_power[1] |=> !port_power[1]) else $error("port clear missed");
endmodule
bind usbrhb_top usbrhb_chk #(.NUM_PORTS(NUM_PORTS)) usbrhb_chk_i (.*);

// *** testbench/usbrhb_bench.sv ***
`include "usbrhb_cfg.svh"
module usbrhb_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import usbrhb_pkg::*;
  localparam logic [31:0] A = `USBRHB_ADDR_PORT_CFG_B;
  logic clk_sys = 1'b0, rst_b = 1'b0, ub = 1'b0, wr = 1'b0, rd = 1'b0, aon = 1'b0, pps = 1'b0, sg = 1'b0, cg = 1'b0;
  logic [31:0] ad = '0, wd = '0, rdat;
  logic [2:1] sp = '0, cp = '0, pw, rf, pm;
  int num_errors = 0, n_compared = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  usbrhb_top usbrhb_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .usb_bus_reset(ub), .reg_addr(ad), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .ports_always_on_setting(aon), .per_port_switch_select(pps),
    .set_global_power(sg), .clear_global_power(cg), .set_port_power(sp), .clear_port_power(cp), .port_power(pw),
    .port_removable_flags(rf), .port_power_select_mask(pm));
  ////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      $display("Error %s exp %h got %h", n, e, s);
      num_errors++;
    end
  endtask
  task wr_t(input logic [31:0] a, d);
    @(posedge clk_sys); ad <= a; wd <= d; wr <= 1'b1;
    @(posedge clk_sys); wr <= 1'b0;
  endtask
  // read data only stand one cycle, so look just after the edge
  task rd_t(input logic [31:0] a, e);
    @(posedge clk_sys); ad <= a; rd <= 1'b1;
    @(posedge clk_sys); rd <= 1'b0;
    #1 chk("rdata", rdat, e);
  endtask
  task pc(input logic g, c, input logic [2:1] s, k, e);
    @(posedge clk_sys); sg <= g; cg <= c; sp <= s; cp <= k;
    @(posedge clk_sys); {sg, cg, sp, cp} <= '0;
    #1 chk("power", {30'h0, pw}, {30'h0, e});
  endtask
  task close_out;
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task t_reg;
    rd_t(A, 32'h00000000);
    wr_t(A, 32'hFFFFFFFF);
    rd_t(A, 32'h00060006);
    chk("flags", {30'h0, rf}, 32'h00000003);
    chk("mask", {30'h0, pm}, 32'h00000003);
    wr_t(A + 32'h4, 32'h0);
    rd_t(A + 32'h4, 32'h0);
    @(posedge clk_sys);
    ub <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ub <= 1'b0;
    rd_t(A, 32'h00060006);
  endtask
  task t_pwr;
    wr_t(A, 32'h00020004);
    pc(1, 0, 0, 0, 2'b11);
    chk("flags", {30'h0, rf}, 32'h00000002);
    chk("mask", {30'h0, pm}, 32'h00000001);
    pc(0, 0, 0, 2'b11, 2'b11);
    @(posedge clk_sys);
    pps <= 1'b1;
    pc(0, 1, 0, 0, 2'b01);
    pc(0, 0, 2'b10, 2'b01, 2'b00);
    pc(1, 0, 2'b01, 0, 2'b11);
    // set and clear together: clear wins on both ports
    pc(1, 1, 2'b01, 2'b01, 2'b00);
    @(posedge clk_sys);
    aon <= 1'b1;
    pc(0, 1, 0, 2'b11, 2'b11);
    @(posedge clk_sys);
    aon <= 1'b0;
    pps <= 1'b0;
  endtask
  task t_rst;
    @(posedge clk_sys); rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_t(A, 32'h00000000);
    chk("power", {30'h0, pw}, 32'h00000000);
  endtask
  // ceiling far above the few dozen cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1000) begin
      num_errors++;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reg;
    t_pwr;
    t_rst;
    close_out;
  end
endmodule
